// ---- shared/ctp_pkg.sv ----
/*
 * Shared constants: register numbers, fields, encodings, resets.
 * Assumes a 12-bit register number from the pipeline and 32-bit data.
 */
package ctp_pkg;
    // ==========================================================
    // register numbers
    localparam logic [11:0] SUP_STATE_N     = 12'h100;
    localparam logic [11:0] SUP_INTEN_N     = 12'h104;
    localparam logic [11:0] SUP_VEC_N       = 12'h105;
    localparam logic [11:0] SUP_SCRATCH_N   = 12'h140;
    localparam logic [11:0] SUP_EPC_N       = 12'h141;
    localparam logic [11:0] SUP_REASON_N    = 12'h142;
    localparam logic [11:0] SUP_BADVAL_N    = 12'h143;
    localparam logic [11:0] SUP_INTPEND_N   = 12'h144;
    localparam logic [11:0] MACH_STATE_N    = 12'h300;
    localparam logic [11:0] ISA_EXT_N       = 12'h301;
    localparam logic [11:0] EXC_DELEG_N     = 12'h302;
    localparam logic [11:0] INT_DELEG_N     = 12'h303;
    localparam logic [11:0] MACH_INTEN_N    = 12'h304;
    localparam logic [11:0] MACH_VEC_N      = 12'h305;
    localparam logic [11:0] MACH_SCRATCH_N  = 12'h340;
    localparam logic [11:0] MACH_EPC_N      = 12'h341;
    localparam logic [11:0] MACH_REASON_N   = 12'h342;
    localparam logic [11:0] MACH_BADVAL_N   = 12'h343;
    localparam logic [11:0] MACH_INTPEND_N  = 12'h344;
    localparam logic [11:0] PROT_CFG_N      = 12'h3A0;
    localparam logic [11:0] PROT_BOUND0_N   = 12'h3B0;
    localparam logic [11:0] CYC_LO_N        = 12'hB00;
    localparam logic [11:0] RET_LO_N        = 12'hB02;
    localparam logic [11:0] CYC_HI_N        = 12'hB80;
    localparam logic [11:0] RET_HI_N        = 12'hB82;
    localparam logic [11:0] VENDOR_N        = 12'hF11;
    localparam logic [11:0] ARCH_N          = 12'hF12;
    localparam logic [11:0] IMPL_N          = 12'hF13;
    localparam logic [11:0] HART_N          = 12'hF14;

    // ==========================================================
    // field layout of one entry configuration byte
    localparam int CFG_LOCK  = 7;
    localparam int CFG_MODEH = 4;
    localparam int CFG_MODEL = 3;
    localparam int CFG_EXEC  = 2;
    localparam int CFG_WRITE = 1;
    localparam int CFG_READ  = 0;
    localparam int ENTRIES   = 4;
    localparam logic [1:0] MATCH_OFF = 2'h0;
    localparam logic [1:0] MATCH_TOR = 2'h1;

    // trap vector selection encodings
    localparam logic [1:0] VEC_DIRECT   = 2'h0;
    localparam logic [1:0] VEC_DISPATCH = 2'h1;

    // privilege levels and access kinds
    localparam logic [1:0] PRIV_U = 2'h0;
    localparam logic [1:0] PRIV_S = 2'h1;
    localparam logic [1:0] PRIV_M = 2'h3;
    typedef enum logic [1:0] {
        ACC_READ  = 2'h0,
        ACC_WRITE = 2'h1,
        ACC_EXEC  = 2'h3
    } ctp_access_e;

    // fault causes
    localparam logic [4:0] CAUSE_FETCH_FAULT = 5'h01;
    localparam logic [4:0] CAUSE_LOAD_FAULT  = 5'h05;
    localparam logic [4:0] CAUSE_STORE_FAULT = 5'h07;

    // resets and identity codes (identity values arbitrary)
    localparam logic [31:0] RESET_WORD  = 32'h0000_0000;
    localparam logic [31:0] ISA_VALUE   = 32'h4014_1105;
    localparam logic [31:0] VENDOR_VAL  = 32'h0000_0A5A;
    localparam logic [31:0] ARCH_VAL    = 32'h0000_0001;
    localparam logic [31:0] IMPL_VAL    = 32'h0000_0001;
    localparam logic [31:0] HART_VAL    = 32'h0000_0000;
endpackage : ctp_pkg

// ---- src/ctp_csr_unit.sv ----
/*
 * Privileged register set with trap vector and four-entry
 * top-of-range protection checker, plus bus write-error faults.
 * Assumes same-clock pipeline inputs held one cycle and
 * trapTake raised at writeback.
 */
// Function
// - vector holds aligned origin and selection field
// - selection 0 direct, 1 dispatch, others dropped
// - direct mode jumps to origin always
// - dispatch mode adds four times interrupt cause
// - four entries, granularity zero, top-of-range only
// - one config register packs four bytes
// - four bound registers hold address bits 33:2
// - lock, reserved, mode, exec, write, read layout
// - permission bits allow or deny each access
// - mode keeps only off and top-of-range
// - lock blocks writes to entry and bound
// - locked top-of-range also guards previous bound
// - lock clears only on hart reset
// - partly covered access fails at any level
// - unlocked match passes machine, else permissions
// - no match passes machine, fails others
// - failed check raises fault with access-type cause, or cause seven on a same-cycle bus write error
// - bus write error becomes store fault seven
// - cached and uncached store errors both fault
// - information, isa, cause, bad value read-only
// - writable 64-bit cycle and retired counters
// - supervisor read-write register set provided
// - trap jumps only after writeback of faulting op
module ctp_csr_unit
    import ctp_pkg::*;
(
    input  wire logic        clock,          // core clock
    input  wire logic        rstn,           // hart reset, low
    input  wire logic        csrWrite,       // register write strobe
    input  wire logic        csrRead,        // register read strobe
    input  wire logic [11:0] csrNum,         // register number
    input  wire logic [31:0] csrWData,       // write data
    input  wire logic [1:0]  privLevel,      // current privilege
    input  wire logic        chkValid,       // access check request
    input  wire logic [33:0] chkAddr,        // first byte address
    input  wire logic [2:0]  chkSize,        // bytes minus one
    input  wire logic [1:0]  chkKind,        // read, write or fetch
    input  wire logic        cachedWrErr,    // cached path error
    input  wire logic        ioWrErr,        // uncached path error
    input  wire logic        trapTake,       // trap at writeback
    input  wire logic        trapAsync,      // trap is interrupt
    input  wire logic [4:0]  trapCause,      // trap cause number
    input  wire logic [31:0] trapPc,         // pc of trapped op
    input  wire logic [31:0] trapValue,      // bad address / insn
    input  wire logic        retire,         // instruction retired
    output logic [31:0]      csrRData,       // read data
    output logic             csrIllegal,     // unmapped access or read-only write
    output logic             accessFault,    // check failed, pulse
    output logic [4:0]       faultCause,     // fault cause code
    output logic             storeFault,     // bus write error, pulse
    output logic             trapJump,       // redirect pc, pulse
    output logic [31:0]      trapTarget      // handler address
);

    // ==========================================================
    // storage
    logic [31:0] supReg_r [8];      // supervisor set, indexed
    logic [31:0] machState_r;       // machine status
    logic [31:0] excDeleg_r;        // exception delegation
    logic [31:0] intDeleg_r;        // interrupt delegation
    logic [31:0] machIntEn_r;       // machine int enable
    logic [31:0] machVec_r;         // machine trap vector
    logic [31:0] machScratch_r;     // machine scratch
    logic [31:0] machEpc_r;         // machine exception pc
    logic [31:0] machReason_r;      // machine trap cause
    logic [31:0] machBadVal_r;      // machine bad value
    logic [31:0] machIntPend_r;     // machine int pending
    logic [7:0]  entCfg_r [ENTRIES];   // entry configurations
    logic [31:0] entBound_r [ENTRIES]; // entry bounds
    logic [63:0] cycCount_r;        // cycle counter
    logic [63:0] retCount_r;        // retired counter

    logic        wrHit;             // write strobe, any number
    logic [2:0]  supIdx;            // supervisor slot index
    logic        supHit;            // number is a supervisor reg
    logic [1:0]  boundIdx;          // bound register index
    logic        boundHit;          // number is a bound reg

    assign wrHit = csrWrite;

    // supervisor slot decode
    always_comb begin
        supHit = 1'b1;
        case (csrNum)
            SUP_STATE_N:   supIdx = 3'h0;
            SUP_INTEN_N:   supIdx = 3'h1;
            SUP_VEC_N:     supIdx = 3'h2;
            SUP_SCRATCH_N: supIdx = 3'h3;
            SUP_EPC_N:     supIdx = 3'h4;
            SUP_REASON_N:  supIdx = 3'h5;
            SUP_BADVAL_N:  supIdx = 3'h6;
            SUP_INTPEND_N: supIdx = 3'h7;
            default: begin
                supIdx = 3'h0;
                supHit = 1'b0;
            end
        endcase
    end

    assign boundIdx = csrNum[1:0];
    assign boundHit = (csrNum[11:2] == PROT_BOUND0_N[11:2]);

    // ==========================================================
    // legalising helpers
    // bad selection keeps old one
    function automatic logic [31:0] vec_legal(
        input logic [31:0] nv,
        input logic [31:0] old
    );
        logic [1:0] m;
        m = nv[1:0];
        if (m == VEC_DIRECT || m == VEC_DISPATCH) begin
            return nv;
        end
        return {nv[31:2], old[1:0]};
    endfunction : vec_legal

    // reserved bits read 0, bad mode keeps old
    function automatic logic [7:0] cfg_legal(
        input logic [7:0] nv,
        input logic [7:0] old
    );
        logic [1:0] m;
        m = nv[CFG_MODEH:CFG_MODEL];
        if (m != MATCH_OFF && m != MATCH_TOR) begin
            m = old[CFG_MODEH:CFG_MODEL];
        end
        return {nv[CFG_LOCK], 2'h0, m, nv[2:0]};
    endfunction : cfg_legal

    // ==========================================================
    // supervisor registers, read-write, vector legalised
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 8; i++) begin
                supReg_r[i] <= RESET_WORD;
            end
        end else if (wrHit && supHit) begin
            if (supIdx == 3'h2) begin
                supReg_r[supIdx] <= vec_legal(csrWData,
                                               supReg_r[supIdx]);
            end else begin
                supReg_r[supIdx] <= csrWData;
            end
        end
    end

    // ==========================================================
    // machine setup registers
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            machState_r   <= RESET_WORD;
            excDeleg_r    <= RESET_WORD;
            intDeleg_r    <= RESET_WORD;
            machIntEn_r   <= RESET_WORD;
            machVec_r     <= RESET_WORD;
            machScratch_r <= RESET_WORD;
            machIntPend_r <= RESET_WORD;
        end else if (wrHit) begin
            case (csrNum)
                MACH_STATE_N:   machState_r   <= csrWData;
                EXC_DELEG_N:    excDeleg_r    <= csrWData;
                INT_DELEG_N:    intDeleg_r    <= csrWData;
                MACH_INTEN_N:   machIntEn_r   <= csrWData;
                MACH_VEC_N:     machVec_r     <= vec_legal(
                                    csrWData, machVec_r);
                MACH_SCRATCH_N: machScratch_r <= csrWData;
                MACH_INTPEND_N: machIntPend_r <= csrWData;
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // trap capture: cause, bad value from hardware only,
    // software writes dropped
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            machEpc_r    <= RESET_WORD;
            machReason_r <= RESET_WORD;
            machBadVal_r <= RESET_WORD;
        end else if (trapTake) begin
            machEpc_r    <= trapPc;
            machReason_r <= {trapAsync, 26'h0, trapCause};
            machBadVal_r <= trapValue;
        end else if (wrHit && csrNum == MACH_EPC_N) begin
            machEpc_r <= csrWData;
        end
    end

    // ==========================================================
    // handler address, registered so the jump
    // follows writeback
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            trapJump   <= 1'b0;
            trapTarget <= RESET_WORD;
        end else begin
            trapJump <= trapTake;
            if (trapTake) begin
                if (machVec_r[1:0] == VEC_DISPATCH && trapAsync) begin
                    trapTarget <= {machVec_r[31:2], 2'h0}
                                  + {25'h0, trapCause, 2'h0};
                end else begin
                    trapTarget <= {machVec_r[31:2], 2'h0};
                end
            end
        end
    end

    // ==========================================================
    // protection registers, gated by lock
    logic [3:0] cfgLocked;      // entry lock flags
    logic [3:0] boundLocked;    // bound write blocked
    genvar g;
    generate
        for (g = 0; g < ENTRIES; g++) begin : g_lock
            assign cfgLocked[g] = entCfg_r[g][CFG_LOCK];
            if (g < ENTRIES - 1) begin : g_next
                // locked TOP_OF_RANGE_MATCHING successor guards bound
                assign boundLocked[g] = cfgLocked[g]
                    | (cfgLocked[g+1]
                       && entCfg_r[g+1][CFG_MODEH:CFG_MODEL]
                          == MATCH_TOR);
            end else begin : g_last
                assign boundLocked[g] = cfgLocked[g];
            end
        end
    endgenerate

    // reset is the only way a lock is lifted
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < ENTRIES; i++) begin
                entCfg_r[i]   <= 8'h00;
                entBound_r[i] <= RESET_WORD;
            end
        end else if (wrHit) begin
            for (int i = 0; i < ENTRIES; i++) begin
                // locked bytes ignore writes
                if (csrNum == PROT_CFG_N && !cfgLocked[i]) begin
                    entCfg_r[i] <= cfg_legal(csrWData[8*i +: 8],
                                             entCfg_r[i]);
                end
            end
            if (boundHit && !boundLocked[boundIdx]) begin
                entBound_r[boundIdx] <= csrWData;
            end
        end
    end

    // ==========================================================
    // counters: write beats increment
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cycCount_r <= 64'h0;
            retCount_r <= 64'h0;
        end else begin
            cycCount_r <= cycCount_r + 64'h1;
            if (retire) begin
                retCount_r <= retCount_r + 64'h1;
            end
            if (wrHit) begin
                case (csrNum)
                    CYC_LO_N: cycCount_r[31:0]  <= csrWData;
                    CYC_HI_N: cycCount_r[63:32] <= csrWData;
                    RET_LO_N: retCount_r[31:0]  <= csrWData;
                    RET_HI_N: retCount_r[63:32] <= csrWData;
                    default: begin
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // read mux
    logic [31:0] rdVal;     // selected read word
    logic        rdMiss;    // number not mapped
    always_comb begin
        rdVal  = RESET_WORD;
        rdMiss = 1'b0;
        if (supHit) begin
            rdVal = supReg_r[supIdx];
        end else if (boundHit) begin
            rdVal = entBound_r[boundIdx];
        end else begin
            case (csrNum)
                MACH_STATE_N:   rdVal = machState_r;
                ISA_EXT_N:      rdVal = ISA_VALUE;
                EXC_DELEG_N:    rdVal = excDeleg_r;
                INT_DELEG_N:    rdVal = intDeleg_r;
                MACH_INTEN_N:   rdVal = machIntEn_r;
                MACH_VEC_N:     rdVal = machVec_r;
                MACH_SCRATCH_N: rdVal = machScratch_r;
                MACH_EPC_N:     rdVal = machEpc_r;
                MACH_REASON_N:  rdVal = machReason_r;
                MACH_BADVAL_N:  rdVal = machBadVal_r;
                MACH_INTPEND_N: rdVal = machIntPend_r;
                PROT_CFG_N:     rdVal = {entCfg_r[3], entCfg_r[2],
                                         entCfg_r[1], entCfg_r[0]};
                CYC_LO_N:       rdVal = cycCount_r[31:0];
                CYC_HI_N:       rdVal = cycCount_r[63:32];
                RET_LO_N:       rdVal = retCount_r[31:0];
                RET_HI_N:       rdVal = retCount_r[63:32];
                VENDOR_N:       rdVal = VENDOR_VAL;
                ARCH_N:         rdVal = ARCH_VAL;
                IMPL_N:         rdVal = IMPL_VAL;
                HART_N:         rdVal = HART_VAL;
                default:        rdMiss = 1'b1;
            endcase
        end
    end

    // writes to read-only numbers flagged
    logic roWrite;  // write to a read-only number
    assign roWrite = (csrNum[11:10] == 2'h3) || csrNum == ISA_EXT_N
                  || csrNum == MACH_REASON_N
                  || csrNum == MACH_BADVAL_N;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            csrRData   <= RESET_WORD;
            csrIllegal <= 1'b0;
        end else begin
            csrRData   <= csrRead ? rdVal : RESET_WORD;
            csrIllegal <= ((csrRead || csrWrite) && rdMiss)
                       || (csrWrite && roWrite);
        end
    end

    // ==========================================================
    // protection check, top-of-range only, granularity zero
    logic [33:0] accLast;       // last byte of the access
    logic [3:0]  fullHit;       // entry covers every byte
    logic [3:0]  partHit;       // entry covers some bytes
    logic [33:0] lowB [ENTRIES];  // lower bound per entry
    logic [33:0] highB [ENTRIES]; // upper bound, exclusive
    assign accLast = chkAddr + {31'h0, chkSize};

    generate
        for (g = 0; g < ENTRIES; g++) begin : g_match
            logic on;   // entry enabled in top-of-range
            if (g == 0) begin : g_first
                assign lowB[g] = 34'h0;
            end else begin : g_rest
                assign lowB[g] = {entBound_r[g-1], 2'h0};
            end
            assign highB[g] = {entBound_r[g], 2'h0};
            assign on = entCfg_r[g][CFG_MODEH:CFG_MODEL]
                        == MATCH_TOR;
            assign fullHit[g] = on && chkAddr >= lowB[g]
                                && accLast < highB[g];
            assign partHit[g] = on && chkAddr < highB[g]
                                && accLast >= lowB[g];
        end
    endgenerate

    logic passNow;  // check outcome
    always_comb begin
        logic [7:0] c;
        logic       perm;
        logic       decided;
        c       = 8'h00;
        perm    = 1'b0;
        decided = 1'b0;
        passNow = (privLevel == PRIV_M);
        for (int i = 0; i < ENTRIES; i++) begin
            if (!decided && partHit[i]) begin
                decided = 1'b1;
                c = entCfg_r[i];
                case (chkKind)
                    ACC_READ:  perm = c[CFG_READ];
                    ACC_WRITE: perm = c[CFG_WRITE];
                    ACC_EXEC:  perm = c[CFG_EXEC];
                    default:   perm = 1'b0;
                endcase
                if (!fullHit[i]) begin
                    passNow = 1'b0;
                end else if (!c[CFG_LOCK] && privLevel == PRIV_M) begin
                    passNow = 1'b1;
                end else begin
                    passNow = perm;
                end
            end
        end
    end

    // fault outputs, one cycle later
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            accessFault <= 1'b0;
            faultCause  <= 5'h00;
            storeFault  <= 1'b0;
        end else begin
            accessFault <= chkValid && !passNow;
            storeFault  <= cachedWrErr || ioWrErr;
            if (cachedWrErr || ioWrErr) begin
                faultCause <= CAUSE_STORE_FAULT;
            end else if (chkValid && !passNow) begin
                case (chkKind)
                    ACC_EXEC:  faultCause <= CAUSE_FETCH_FAULT;
                    ACC_WRITE: faultCause <= CAUSE_STORE_FAULT;
                    default:   faultCause <= CAUSE_LOAD_FAULT;
                endcase
            end
        end
    end

endmodule : ctp_csr_unit

// ---- verification/ctp_bus_model.sv ----
/*
 * Bus stand-in: error write responses on either path.
 * Assumes nonblocking requests from the bench.
 */
module ctp_bus_model (
    input  wire logic       clock,
    input  wire logic [1:0] failReq,
    output logic            cachedWrErr = 1'b0,
    output logic            ioWrErr     = 1'b0
);
    // ==========================================================
    // error response one falling edge after the request
    always @(negedge clock) begin
        cachedWrErr <= failReq[0];
        ioWrErr     <= failReq[1];
    end
endmodule : ctp_bus_model

// ---- verification/ctp_csr_unit_props.sv ----
/*
 * Port checker, bound to ctp_csr_unit.
 * Assumes one clock and async low reset.
 */
module ctp_csr_unit_props
    import ctp_pkg::*;
(
    input wire logic        clock,
    input wire logic        rstn,
    input wire logic        csrWrite,
    input wire logic [11:0] csrNum,
    input wire logic        chkValid,
    input wire logic [1:0]  chkKind,
    input wire logic        cachedWrErr,
    input wire logic        ioWrErr,
    input wire logic        trapTake,
    input wire logic        csrIllegal,
    input wire logic        accessFault,
    input wire logic [4:0]  faultCause,
    input wire logic        storeFault,
    input wire logic        trapJump,
    input wire logic [31:0] trapTarget
);
    // ==========================================================
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);
    property p_store;
        (cachedWrErr || ioWrErr) |=> storeFault && faultCause == 5'h07;
    endproperty
    a_store: assert property (p_store)
        else $error("no store fault");
    property p_nostore;
        !(cachedWrErr || ioWrErr) |=> !storeFault;
    endproperty
    a_nostore: assert property (p_nostore)
        else $error("stray store fault");
    property p_jump;
        trapTake |=> trapJump;
    endproperty
    a_jump: assert property (p_jump)
        else $error("no jump");
    property p_nojump;
        !trapTake |=> !trapJump;
    endproperty
    a_nojump: assert property (p_nojump)
        else $error("stray jump");
    property p_align;
        trapJump |-> trapTarget[1:0] == 2'h0;
    endproperty
    a_align: assert property (p_align)
        else $error("target unaligned");
    property p_nofault;
        !chkValid |=> !accessFault;
    endproperty
    a_nofault: assert property (p_nofault)
        else $error("stray fault");
    property p_cause;
        accessFault && !$past(cachedWrErr || ioWrErr) |-> faultCause ==
            ($past(chkKind) == 2'h3 ? 5'h01 :
             $past(chkKind) == 2'h1 ? 5'h07 : 5'h05);
    endproperty
    a_cause: assert property (p_cause)
        else $error("wrong cause");
    property p_ro;
        csrWrite && (csrNum[11:10] == 2'h3 || csrNum == 12'h342 ||
            csrNum == 12'h343 || csrNum == 12'h301) |=> csrIllegal;
    endproperty
    a_ro: assert property (p_ro)
        else $error("no illegal flag");
endmodule : ctp_csr_unit_props
bind ctp_csr_unit ctp_csr_unit_props ctp_csr_unit_props_inst (.clock,
    .rstn, .csrWrite, .csrNum, .chkValid, .chkKind, .cachedWrErr,
    .csrIllegal,
    .ioWrErr, .trapTake, .accessFault, .faultCause, .storeFault,
    .trapJump, .trapTarget);

// ---- verification/csr_trap_vector_pmp_unit_tb.sv ----
/*
 * Bench: register, check, trap, bus-error calls.
 * Assumes package and bus model compiled first.
 */
module csr_trap_vector_pmp_unit_tb;
    import ctp_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock = 1'b0, rstn = 1'b0, csrWrite = 1'b0;
    logic        csrRead = 1'b0, chkValid = 1'b0, trapTake = 1'b0;
    logic        trapAsync = 1'b0, retire = 1'b0;
    logic [11:0] csrNum = 12'h000;
    logic [31:0] csrWData = 32'h0, trapPc = 32'h1234, trapValue = 32'h0;
    logic [33:0] chkAddr = 34'h0;
    logic [2:0]  chkSize = 3'h0;
    logic [1:0]  privLevel = 2'h0, chkKind = 2'h0, failReq = 2'h0;
    logic [4:0]  trapCause = 5'h00, faultCause;
    logic [31:0] csrRData, trapTarget;
    logic        csrIllegal, accessFault, storeFault, trapJump;
    logic        cachedWrErr, ioWrErr;
    int          numErrors = 0, checks = 0;
    always #25 clock = ~clock;
    ctp_bus_model ctp_bus_model_inst (.clock, .failReq, .cachedWrErr,
        .ioWrErr);
    ctp_csr_unit ctp_csr_unit_inst (.clock, .rstn, .csrWrite, .csrRead,
        .csrNum, .csrWData, .privLevel, .chkValid, .chkAddr, .chkSize,
        .chkKind, .cachedWrErr, .ioWrErr, .trapTake, .trapAsync,
        .trapCause, .trapPc, .trapValue, .retire, .csrRData, .csrIllegal,
        .accessFault, .faultCause, .storeFault, .trapJump, .trapTarget);
    // ==========================================================
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            numErrors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr(input logic [11:0] n, input logic [31:0] d);
        @(negedge clock);
        {csrWrite, csrNum, csrWData} = {1'b1, n, d};
        @(negedge clock);
        csrWrite = 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] n, input logic [31:0] e);
        @(negedge clock);
        {csrRead, csrNum} = {1'b1, n};
        @(negedge clock);
        csrRead = 1'b0;
        cmp(csrRData, e);
    endtask : rd
    task automatic chk(input logic [1:0] p, input logic [33:0] a,
                       input logic [2:0] s, input logic [1:0] k,
                       input logic f, input logic [4:0] c);
        @(negedge clock);
        {privLevel, chkAddr, chkSize, chkKind, chkValid} = {p, a, s, k, 1'b1};
        @(negedge clock);
        chkValid = 1'b0;
        cmp(32'(accessFault), 32'(f));
        if (f) cmp(32'(faultCause), 32'(c));
    endtask : chk
    task automatic trap(input logic a, input logic [31:0] e);
        @(negedge clock);
        {trapTake, trapAsync, trapCause} = {1'b1, a, 5'h03};
        @(negedge clock);
        trapTake = 1'b0;
        cmp(32'(trapJump), 32'h1);
        cmp(trapTarget, e);
    endtask : trap
    task automatic berr(input logic [1:0] p);
        @(negedge clock);
        failReq <= p;
        @(negedge clock);
        failReq <= 2'h0;
        @(negedge clock);
        cmp(32'(storeFault), 32'h1);
        cmp(32'(faultCause), 32'h7);
    endtask : berr
    task automatic report_and_stop;
        if (numErrors == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    // ==========================================================
    initial begin
        #50000;
        numErrors++;
        report_and_stop();
    end
    initial begin
        repeat (5) @(negedge clock);
        rstn = 1'b1;
        rd(ISA_EXT_N, ISA_VALUE);
        wr(MACH_REASON_N, 32'hFFFF_FFFF);
        cmp(32'(csrIllegal), 32'h1);
        rd(MACH_REASON_N, 32'h0);
        wr(VENDOR_N, 32'h1);
        cmp(32'(csrIllegal), 32'h1);
        wr(SUP_SCRATCH_N, 32'hA5A5_0001);
        rd(SUP_SCRATCH_N, 32'hA5A5_0001);
        wr(RET_LO_N, 32'h10);
        retire = 1'b1;
        @(negedge clock);
        retire = 1'b0;
        rd(RET_LO_N, 32'h11);
        wr(CYC_HI_N, 32'h5);
        rd(CYC_HI_N, 32'h5);
        wr(MACH_VEC_N, 32'h101);
        rd(MACH_VEC_N, 32'h101);
        wr(MACH_VEC_N, 32'h202);
        rd(MACH_VEC_N, 32'h201);
        trap(1'b1, 32'h20C);
        trap(1'b0, 32'h200);
        rd(MACH_REASON_N, 32'h3);
        wr(MACH_VEC_N, 32'h300);
        trap(1'b1, 32'h300);
        chk(PRIV_U, 34'h10, 3'h3, ACC_READ, 1'b1, 5'h05);
        chk(PRIV_M, 34'h10, 3'h3, ACC_WRITE, 1'b0, 5'h00);
        wr(PROT_BOUND0_N, 32'h100);
        wr(PROT_CFG_N, 32'h1F);
        rd(PROT_CFG_N, 32'h07);
        wr(PROT_CFG_N, 32'h69);
        rd(PROT_CFG_N, 32'h09);
        chk(PRIV_U, 34'h10, 3'h3, ACC_READ, 1'b0, 5'h00);
        chk(PRIV_U, 34'h10, 3'h3, ACC_WRITE, 1'b1, 5'h07);
        chk(PRIV_S, 34'h10, 3'h3, ACC_EXEC, 1'b1, 5'h01);
        chk(PRIV_M, 34'h3FC, 3'h7, ACC_READ, 1'b1, 5'h05);
        wr(PROT_CFG_N, 32'h0088_0089);
        chk(PRIV_M, 34'h10, 3'h3, ACC_WRITE, 1'b1, 5'h07);
        chk(PRIV_M, 34'h10, 3'h3, ACC_READ, 1'b0, 5'h00);
        wr(PROT_CFG_N, 32'h0);
        rd(PROT_CFG_N, 32'h0088_0089);
        wr(PROT_BOUND0_N, 32'h200);
        rd(PROT_BOUND0_N, 32'h100);
        wr(PROT_BOUND0_N + 12'h001, 32'h55);
        rd(PROT_BOUND0_N + 12'h001, 32'h0);
        berr(2'h1);
        berr(2'h2);
        report_and_stop();
    end
endmodule : csr_trap_vector_pmp_unit_tb
